// file: hdl/ahpms_pkg.sv
// constants and pin bundle of the shared host pin selector
// assumes a single 20 MHz system clock; host pins are asynchronous to it
package ahpms_pkg;

    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CHAINS = 3;

    // shared pin positions on the parallel data bus
    localparam int POS_SEL_A = 0;
    localparam int POS_SEL_B = 1;
    localparam int POS_SEL_C = 2;
    localparam int POS_CHAIN_C = 3;
    localparam int POS_CHAIN_B = 4;
    localparam int POS_CHAIN_A = 5;
    localparam int POS_SCLK = 6;
    localparam int POS_HBF = 7;
    localparam int POS_DOUT_A = 8;
    localparam int POS_DOUT_B = 9;
    localparam int POS_DOUT_C = 10;

    // reset values and enable masks
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] OE_NONE = 16'h0000;
    localparam logic [15:0] OE_WORD = 16'hffff;
    localparam logic [15:0] OE_BYTE = 16'hff00;

    // host pins as they arrive from outside the clock domain
    typedef struct packed {
        logic serial_parallel_select;
        logic word_byte_select;
        logic chip_select_n;
        logic read_n;
        logic conversion_start;
        logic [15:0] data;
    } ahpms_pins_type;

endpackage

// file: hdl/ahpms_fifo.sv
// first-in first-out buffer for conversion results
// assumes producer and consumer both sit on clk_sys
`timescale 1ns/10ps
module ahpms_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;

    // ready is a register so the producer sees a settled level
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end

endmodule

// file: hdl/ahpms_pin_mux.sv
// shared host pin selector: parallel word, parallel byte and serial modes
// assumes host pins are asynchronous; results come from core logic on clk_sys
//
// Notes on behaviour
// RULE_01: word mode: shared pin is data bit seven
// RULE_02: byte mode: shared pin is high-byte-first input
// RULE_03: byte mode: first byte chosen by high-byte-first
// RULE_04: serial mode: shared pin is chain enable
// RULE_05: host ties chain enable low without chaining
// RULE_06: serial mode: bit six is serial clock input
// RULE_07: parallel mode: multipurpose pins are three-state outputs
// RULE_08: chaining takes bits five, four, three as inputs
// RULE_09: host ties chain inputs low without chaining
// RULE_10: select C enables serial output C
// RULE_11: select B enables serial output B
// RULE_12: host holds select A high in serial
// RULE_13: busy high from conversion start until latched
// RULE_14: host starts no conversion while busy
// RULE_15: bus driven only with select and read low; the code drives serial outputs from select A, B, C alone
// RULE_16: byte mode needs two reads per result
// RULE_17: serial frame presents most significant bit first
// RULE_18: data pins float when select or read high; the code drives serial outputs from select A, B, C alone
`timescale 1ns/10ps
module ahpms_pin_mux (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // host pins
    input wire ahpms_pkg::ahpms_pins_type pins_in,
    output logic [15:0] data_out,
    output logic [15:0] data_oe,
    output logic busy,
    // results from the converter core
    input wire logic result_valid,
    input wire logic [15:0] result_data,
    output logic result_ready
);
    import ahpms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; only pin_sync and later stages feed logic

    ahpms_pins_type pin_meta;
    ahpms_pins_type pin_sync;
    ahpms_pins_type pin_prev;

    always_ff @(posedge clk_sys) begin
        pin_meta <= pins_in;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode decode

    wire serial_mode = pin_sync.serial_parallel_select;
    wire byte_mode = ~serial_mode & pin_sync.word_byte_select;
    wire high_byte_first = pin_sync.data[POS_HBF];
    wire chain_enable = serial_mode & pin_sync.data[POS_HBF];
    wire sclk_fall = pin_prev.data[POS_SCLK] & ~pin_sync.data[POS_SCLK];
    wire cs_fall = pin_prev.chip_select_n & ~pin_sync.chip_select_n;
    wire convst_rise = ~pin_prev.conversion_start & pin_sync.conversion_start;
    wire read_active = ~serial_mode & ~pin_sync.chip_select_n & ~pin_sync.read_n;
    wire read_prev = ~pin_prev.serial_parallel_select & ~pin_prev.chip_select_n
        & ~pin_prev.read_n;
    wire read_end = read_prev & ~read_active;
    wire frame = serial_mode & ~pin_sync.chip_select_n;
    wire frame_start = frame & cs_fall;
    // chain inputs count only with chain enable set, so open pins do no harm
    wire [2:0] chain_bits = {pin_sync.data[POS_CHAIN_A], pin_sync.data[POS_CHAIN_B],
        pin_sync.data[POS_CHAIN_C]} & {3{chain_enable}}; // see RULE_04 RULE_08
    wire sel_a = pin_sync.data[POS_SEL_A];
    wire sel_b = pin_sync.data[POS_SEL_B];
    wire sel_c = pin_sync.data[POS_SEL_C];

    ////////////////////////////////////////////////////////////////////////////
    // result buffer; never drains during a read or frame so data stays still

    logic fifo_valid;
    logic [15:0] fifo_data;
    wire drain_ready = ~read_active & ~frame;
    wire pop = fifo_valid & drain_ready;

    ahpms_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(result_valid),
        .in_data(result_data),
        .in_ready(result_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(drain_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // output data registers: newest result and two older ones

    logic [15:0] result_hold [0:CHAINS-1];
    logic [15:0] shift_reg [0:CHAINS-1];
    logic byte_second;
    logic next_busy;

    wire [15:0] cur_word = result_hold[0];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < CHAINS; i++) begin
                result_hold[i] <= RST_WORD;
            end
        end else if (pop) begin
            result_hold[0] <= fifo_data;
            result_hold[1] <= result_hold[0];
            result_hold[2] <= result_hold[1];
        end
    end

    // second byte of a byte-mode pair follows the first read's end
    always_ff @(posedge clk_sys) begin
        if (srst || pop) begin
            byte_second <= 1'b0;
        end else if (read_end && byte_mode) begin
            byte_second <= ~byte_second; // see RULE_16
        end
    end

    // serial shifters load at frame start and move on falling sclk
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < CHAINS; i++) begin
                shift_reg[i] <= RST_WORD;
            end
        end else if (frame_start) begin
            for (int i = 0; i < CHAINS; i++) begin
                shift_reg[i] <= result_hold[i]; // see RULE_17
            end
        end else if (frame && sclk_fall) begin
            for (int i = 0; i < CHAINS; i++) begin
                shift_reg[i] <= {shift_reg[i][14:0], chain_bits[2-i]}; // see RULE_06 RULE_08
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // busy: a new start wins over a latch in the same cycle

    assign next_busy = convst_rise ? 1'b1 : (pop ? 1'b0 : busy); // see RULE_13

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    wire take_high = high_byte_first ^ byte_second; // see RULE_03
    wire [7:0] byte_out = take_high ? cur_word[15:8] : cur_word[7:0];
    wire [2:0] dout_bits = {shift_reg[2][15], shift_reg[1][15], shift_reg[0][15]};
    // select A is honoured too, though the host must keep it high
    wire [2:0] dout_en = {sel_c, sel_b, sel_a}; // see RULE_10 RULE_11 RULE_12
    wire [15:0] ser_out = {5'h00, dout_bits, 8'h00};
    wire [15:0] ser_oe = {5'h00, dout_en, 8'h00};
    wire [15:0] par_out = byte_mode ? {byte_out, 8'h00} : cur_word; // see RULE_01 RULE_03
    // byte mode leaves the low byte floating: bit seven is an input there
    wire [15:0] par_oe = byte_mode ? OE_BYTE : OE_WORD; // see RULE_02 RULE_07
    wire [15:0] next_data_out = serial_mode ? ser_out : par_out;
    wire [15:0] next_data_oe = serial_mode ? ser_oe
        : (read_active ? par_oe : OE_NONE); // see RULE_15 RULE_18

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            data_out <= RST_WORD;
            data_oe <= OE_NONE;
        end else begin
            data_out <= next_data_out;
            data_oe <= next_data_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    AST_WORD_BIT7: assert property ( // see RULE_01
        read_active && !byte_mode |=> data_oe[7] && data_out[7] == $past(cur_word[7]))
        else $error("word mode bit seven not driven with result");
    AST_BYTE_HBF_IN: assert property ( // see RULE_02
        read_active && byte_mode |=> data_oe[7:0] == 8'h00)
        else $error("byte mode drives the low byte");
    AST_BYTE_FIRST: assert property ( // see RULE_03
        read_active && byte_mode && !byte_second && !pop |=>
        data_out[15:8] == ($past(high_byte_first) ? $past(cur_word[15:8])
        : $past(cur_word[7:0])))
        else $error("first byte order wrong");
    AST_CHAIN_IN: assert property ( // see RULE_08
        frame && sclk_fall && !frame_start |=>
        shift_reg[0][0] == ($past(chain_enable) && $past(pin_sync.data[POS_CHAIN_A])))
        else $error("chain input A not shifted in");
    AST_PAR_OE: assert property ( // see RULE_07
        read_active && !byte_mode |=> data_oe == OE_WORD)
        else $error("parallel word read not fully driven");
    AST_SEL_C: assert property ( // see RULE_10
        serial_mode |=> data_oe[POS_DOUT_C] == $past(sel_c) && data_oe[7:0] == 8'h00)
        else $error("serial output C enable wrong");
    AST_SEL_B: assert property ( // see RULE_11
        serial_mode |=> data_oe[POS_DOUT_B] == $past(sel_b))
        else $error("serial output B enable wrong");
    AST_BUSY_SET: assert property ( // see RULE_13
        convst_rise |=> busy)
        else $error("busy not raised on start");
    AST_BUSY_HOLD: assert property ( // see RULE_13
        busy && !pop |=> busy)
        else $error("busy fell before results latched");
    AST_FRAME_MSB: assert property ( // see RULE_17
        frame_start |=> ##1 data_out[POS_DOUT_A] == $past(cur_word[15], 2))
        else $error("frame does not start with the top bit");
    AST_IDLE_FLOAT: assert property ( // see RULE_18
        !serial_mode && (pin_sync.chip_select_n || pin_sync.read_n) |=> data_oe == OE_NONE)
        else $error("parallel bus driven outside a read");

    COV_BYTE_PAIR: cover property (read_end && byte_mode ##[1:200] read_end && byte_mode);
    COV_FRAME: cover property (frame_start ##[1:100] sclk_fall && chain_enable);
    COV_BUSY_DONE: cover property (busy ##1 !busy);
    COV_FULL: cover property (!result_ready);

endmodule

// file: test/ahpms_host_model.sv
// host model: drives the shared pins and resolves the data wires
// assumes the device samples every pin on clk_sys; all changes at falling edges
`timescale 1ns/10ps
module ahpms_host_model
    import ahpms_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // shared pins
    output ahpms_pkg::ahpms_pins_type pins,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe
);
    logic ser;
    logic wbs;
    logic cs_n;
    logic rd_n;
    logic conv;
    logic [15:0] drv;
    logic [15:0] en;
    logic [15:0] flt = 16'h5a5a;
    // idle straps: parallel word mode, strobes high, no data pin driven
    initial begin
        ser = 1'b0;
        wbs = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        conv = 1'b0;
        drv = 16'h0000;
        en = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // a released wire toggles, so a stale level never passes for data
    always @(negedge clk_sys) flt <= ~flt;
    assign pins = {ser, wbs, cs_n, rd_n, conv,
        (data_oe & data_out) | (~data_oe & ((en & drv) | (~en & flt)))};
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // straps: mode pins set, and the data pins enabled by e driven to the levels in d
    task automatic set_pins(input logic s, input logic w, input logic [15:0] e,
            input logic [15:0] d);
        @(negedge clk_sys);
        ser = s;
        wbs = w;
        en = e;
        drv = d;
    endtask
    task automatic strobe(input logic c, input logic r);
        @(negedge clk_sys);
        cs_n = c;
        rd_n = r;
    endtask
    task automatic pulse_start;
        @(negedge clk_sys);
        conv = 1'b1;
        wait_cyc(4);
        conv = 1'b0;
    endtask
    // serial clock idles high and moves only inside the frame, 8 cycles a bit
    task automatic frame(output logic [16:0] a, output logic [16:0] b, output logic [16:0] c);
        @(negedge clk_sys);
        cs_n = 1'b0;
        wait_cyc(8);
        for (int i = 16; i >= 0; i--) begin
            a[i] = data_out[POS_DOUT_A];
            b[i] = data_out[POS_DOUT_B];
            c[i] = data_out[POS_DOUT_C];
            drv[POS_SCLK] = 1'b0;
            wait_cyc(4);
            drv[POS_SCLK] = 1'b1;
            wait_cyc(4);
        end
        cs_n = 1'b1;
    endtask
endmodule

// file: test/tb_ahpms_pin_mux.sv
// testbench: reset, busy, word and byte reads, buffer overfill, serial frames
// assumes ahpms_host_model drives the pins; 20 MHz clock
`timescale 1ns/10ps
module tb_ahpms_pin_mux;
    import ahpms_pkg::*;
    `define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
        $display("[ERR] %0t %s got %h exp %h", $time, m, g, e); end end
    logic clk_sys;
    logic srst;
    ahpms_pins_type pins_in;
    logic [15:0] data_out;
    logic [15:0] data_oe;
    logic busy;
    logic result_valid;
    logic [15:0] result_data;
    logic result_ready;
    int mismatches = 0;
    int comparisons = 0;
    int taken;
    logic took;
    logic [15:0] w;
    logic [16:0] sa, sb, sc;
    ////////////////////////////////////////////////////////////////////////////////
    ahpms_pin_mux u_ahpms_pin_mux (.clk_sys(clk_sys), .srst(srst), .pins_in(pins_in),
        .data_out(data_out), .data_oe(data_oe), .busy(busy), .result_valid(result_valid),
        .result_data(result_data), .result_ready(result_ready));
    ahpms_host_model host (.clk_sys(clk_sys), .pins(pins_in), .data_out(data_out),
        .data_oe(data_oe));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ready is registered, so its level at the falling edge decides the next take
    task automatic push(input logic [15:0] d, input int tries, output logic ok);
        ok = 1'b0;
        @(negedge clk_sys);
        result_valid = 1'b1;
        result_data = d;
        for (int k = 0; k < tries && !ok; k++) begin
            ok = (result_ready === 1'b1);
            @(negedge clk_sys);
        end
        result_valid = 1'b0;
    endtask
    task automatic par_read(input logic [15:0] oe, input logic [15:0] msk, input logic [15:0] d);
        host.strobe(1'b0, 1'b0);
        host.wait_cyc(6);
        `CHK(data_oe, oe, "enable in read")
        `CHK(data_out & msk, d, "read data")
        host.strobe(1'b1, 1'b1);
        host.wait_cyc(6);
        `CHK(data_oe, OE_NONE, "bus released")
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        result_valid = 1'b0;
        result_data = 16'h0000;
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        host.wait_cyc(1);
        `CHK({busy, result_ready, data_oe}, {2'b01, OE_NONE}, "after reset")
        host.pulse_start();
        host.wait_cyc(12);
        `CHK(busy, 1'b1, "busy converting")
        push(16'h1234, 4, took);
        host.wait_cyc(4);
        `CHK(busy, 1'b0, "busy after latch")
        par_read(OE_WORD, 16'hffff, 16'h1234);
        // a held read blocks draining, so the ninth offer meets a full buffer
        host.strobe(1'b0, 1'b0);
        taken = 0;
        for (int i = 0; i < 9; i++) begin
            push(16'hc000 | 16'(i), 4, took);
            taken += took;
        end
        `CHK(taken, FIFO_DEPTH, "words taken")
        `CHK(result_ready, 1'b0, "full refuses")
        `CHK(data_out, 16'h1234, "held in read")
        host.strobe(1'b1, 1'b1);
        host.wait_cyc(20);
        `CHK(result_ready, 1'b1, "drained")
        par_read(OE_WORD, 16'hffff, 16'hc007);
        for (int h = 1; h >= 0; h--) begin
            w = h ? 16'h5aa5 : 16'h3cc3;
            host.set_pins(1'b0, 1'b1, 16'h0080, h ? 16'h0080 : 16'h0000);
            push(w, 4, took);
            host.wait_cyc(4);
            par_read(OE_BYTE, 16'hff00, h ? {w[15:8], 8'h00} : {w[7:0], 8'h00});
            par_read(OE_BYTE, 16'hff00, h ? {w[7:0], 8'h00} : {w[15:8], 8'h00});
        end
        // read strobe stays low throughout serial mode
        host.strobe(1'b1, 1'b0);
        host.set_pins(1'b1, 1'b0, 16'h00ff, 16'h0043);
        host.wait_cyc(6);
        `CHK(data_oe, 16'h0300, "two outputs")
        host.frame(sa, sb, sc);
        `CHK({sa, sb}, {16'h3cc3, 1'b0, 16'h5aa5, 1'b0}, "serial")
        host.set_pins(1'b1, 1'b0, 16'h00ff, 16'h00ef);
        host.wait_cyc(6);
        `CHK(data_oe, 16'h0700, "three outputs")
        host.frame(sa, sb, sc);
        `CHK({sa, sb, sc}, {16'h3cc3, 1'b1, 16'h5aa5, 1'b0, 16'hc007, 1'b1}, "chain")
        // only select A left high: a single serial output
        host.set_pins(1'b1, 1'b0, 16'h00ff, 16'h0041);
        host.wait_cyc(6);
        `CHK(data_oe, 16'h0100, "one output")
        end_of_test();
    end
    initial begin
        repeat (6000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end
endmodule
